// File: hw/smad_defines.svh
/*
  constants for the subtract datapath: opcodes, field positions, flag bit
  positions, reset values and address limits.
  assumes it is included by bare name from the package and the datapath.
*/
// Notes on behaviour
// [RQ1] file minus accumulator, two's complement, 8-bit
// [RQ2] destination bit zero writes accumulator only
// [RQ3] destination bit one writes file register only
// [RQ4] bank bit zero uses fixed access bank
// [RQ5] bank bit one prepends bank pointer
// [RQ6] extended set, bank zero, address <=95: indexed
// [RQ7] with-borrow subtracts accumulator then borrow
// [RQ8] borrow is complement of carry flag
// [RQ9] carry set when no borrow occurred
// [RQ10] negative result clears carry, negative copies bit7
// [RQ11] zero flag set on zero result
// [RQ12] literal minus accumulator, result to accumulator
// [RQ13] literal below accumulator wraps, carry cleared
// [RQ14] one cycle: read q2, compute q3, write q4
// [RQ15] signed range and nibble carry flags updated
`ifndef SMAD_DEFINES_SVH
`define SMAD_DEFINES_SVH

// ----------------------------------------------------------------
// opcode fields of the 16-bit instruction word
// ----------------------------------------------------------------
`define SMAD_OP_LIT_HI        8'h08
`define SMAD_OP_FILE_HI       6'h17
`define SMAD_OP_FILEB_HI      6'h16
`define SMAD_D_BIT            9
`define SMAD_A_BIT            8

// ----------------------------------------------------------------
// status bit positions and limits
// ----------------------------------------------------------------
`define SMAD_ST_C             0
`define SMAD_ST_DC            1
`define SMAD_ST_Z             2
`define SMAD_ST_OV            3
`define SMAD_ST_N             4
`define SMAD_INDEX_MAX        8'h5F
`define SMAD_ACCESS_SPLIT     8'h60
`define SMAD_ACCESS_HI_BANK   4'hF
`define SMAD_ACC_RESET        8'h00
`define SMAD_STATUS_RESET     5'h00
`define SMAD_BANK_RESET       4'h0

`endif

// File: hw/smad_pkg.sv
/*
  types shared by the subtract datapath.
  assumes smad_defines.svh is on the include path.
*/
package smad_pkg;
`include "smad_defines.svh"

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SMAD_Q1 = 2'b00,
    SMAD_Q2 = 2'b01,
    SMAD_Q3 = 2'b10,
    SMAD_Q4 = 2'b11
  } smad_phase_type;

  typedef enum logic [1:0]
  {
    SMAD_OP_NONE  = 2'b00,
    SMAD_OP_LIT   = 2'b01,
    SMAD_OP_FILE  = 2'b10,
    SMAD_OP_FILEB = 2'b11
  } smad_op_type;

  // status flags as held by the core
  typedef struct packed
  {
    logic neg;
    logic signed_range_flag;
    logic zero;
    logic nibble_carry_flag;
    logic carry;
  } smad_status_type;

  // file memory request toward the outside
  typedef struct packed
  {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } smad_file_req_type;

endpackage

// File: hw/smad_datapath.sv
/*
  subtract datapath: literal minus accumulator, file minus accumulator,
  file minus accumulator with borrow, destination and bank selection,
  status flag updates, sequenced over four clock phases per instruction.
  assumes the decoder holds instr stable and pulses instr_valid in the
  cycle before q1; file memory returns read data in the same cycle as rd.
*/
`include "smad_defines.svh"

module smad_datapath
(
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // decoder side
  input  wire logic                       instr_valid,
  input  wire logic [15:0]                instr,
  input  wire logic                       ext_set_en,
  input  wire logic [3:0]                 bank_pointer,
  input  wire logic [11:0]                index_base,
  // file memory side
  input  wire logic [7:0]                 file_rdata,
  output smad_pkg::smad_file_req_type     file_req,
  // architectural state
  output logic      [7:0]                 acc,
  output smad_pkg::smad_status_type       status,
  output logic                            busy,
  output logic                            done
);
  import smad_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // a - b - borrow; returns {carry, nibble carry, signed range, result}
  function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic bin);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] r;
    logic       ov;
    // bit 8 of the sum is the inverted borrow, which is what the carry flag keeps
    full = {1'b0, a} + {1'b0, ~b} + {8'h00, ~bin};   // [RQ1]
    low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~bin};
    r    = full[7:0];
    ov   = (a[7] != b[7]) && (r[7] != a[7]);           // [RQ15]
    sub8 = {full[8], low[4], ov, r};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  smad_phase_type    phase_q,  phase_d;
  smad_op_type       op_q,     op_d;
  logic              busy_q,   busy_d;
  logic              done_q,   done_d;
  logic [15:0]       instr_q,  instr_d;
  logic [7:0]        opnd_q,   opnd_d;
  logic [7:0]        res_q,    res_d;
  logic [10:0]       alu_q,    alu_d;
  logic [7:0]        acc_q,    acc_d;
  smad_status_type   status_q, status_d;
  smad_file_req_type req_q,    req_d;
  logic [11:0]       addr_q,   addr_d;

  // operand address and fields are decoded from the held instruction word
  logic [11:0]       eff_addr;
  logic [7:0]        fa;
  logic              a_bit;

  assign fa    = instr_q[7:0];
  assign a_bit = instr_q[`SMAD_A_BIT];

  // ----------------------------------------------------------------
  // address resolution
  // ----------------------------------------------------------------
  always_comb
  begin
    // indexed mode wins over the access bank split; bank pointer only matters when a=1
    if (ext_set_en && !a_bit && (fa <= `SMAD_INDEX_MAX))
      eff_addr = index_base + {4'h0, fa};              // [RQ6]
    else if (a_bit)
      eff_addr = {bank_pointer, fa};                   // [RQ5]
    else if (fa < `SMAD_ACCESS_SPLIT)
      eff_addr = {4'h0, fa};                           // [RQ4]
    else
      eff_addr = {`SMAD_ACCESS_HI_BANK, fa};           // [RQ4]
  end

  // ----------------------------------------------------------------
  // sequencer and datapath
  // ----------------------------------------------------------------
  always_comb
  begin
    phase_d  = phase_q;
    op_d     = op_q;
    busy_d   = busy_q;
    done_d   = 1'b0;
    instr_d  = instr_q;
    opnd_d   = opnd_q;
    res_d    = res_q;
    alu_d    = alu_q;
    acc_d    = acc_q;
    status_d = status_q;
    addr_d   = addr_q;
    req_d    = '0;
    req_d.addr = addr_q;
    case (phase_q)
      SMAD_Q1:
      begin
        // decode; a new instruction is accepted only while idle
        if (busy_q)
        begin
          phase_d = SMAD_Q2;
          if (op_q != SMAD_OP_LIT)
          begin
            req_d.rd   = 1'b1;                         // [RQ14]
            req_d.addr = eff_addr;
            addr_d     = eff_addr;
          end
        end
        else if (instr_valid)
        begin
          instr_d = instr;
          busy_d  = 1'b1;
          if (instr[15:8] == `SMAD_OP_LIT_HI)
            op_d = SMAD_OP_LIT;
          else if (instr[15:10] == `SMAD_OP_FILE_HI)
            op_d = SMAD_OP_FILE;
          else if (instr[15:10] == `SMAD_OP_FILEB_HI)
            op_d = SMAD_OP_FILEB;
          else
          begin
            // unknown opcodes leave the datapath idle and touch no flag
            op_d   = SMAD_OP_NONE;
            busy_d = 1'b0;
          end
        end
      end
      SMAD_Q2:
      begin
        // operand read: literal or file data
        opnd_d  = (op_q == SMAD_OP_LIT) ? instr_q[7:0] : file_rdata;   // [RQ14]
        phase_d = SMAD_Q3;
      end
      SMAD_Q3:
      begin
        if (op_q == SMAD_OP_FILEB)
          alu_d = sub8(opnd_q, acc_q, ~status_q.carry);  // [RQ7] [RQ8]
        else
          alu_d = sub8(opnd_q, acc_q, 1'b0);             // [RQ1] [RQ12] [RQ13]
        res_d   = alu_d[7:0];
        phase_d = SMAD_Q4;
      end
      SMAD_Q4:
      begin
        // flags come from the registered alu word so q4 never waits on the adder
        status_d.carry             = alu_q[10];          // [RQ9] [RQ10] [RQ13]
        status_d.nibble_carry_flag = alu_q[9];           // [RQ15]
        status_d.signed_range_flag = alu_q[8];           // [RQ15]
        status_d.neg               = res_q[7];           // [RQ10]
        status_d.zero              = (res_q == 8'h00);   // [RQ11]
        if ((op_q == SMAD_OP_LIT) || !instr_q[`SMAD_D_BIT])
          acc_d = res_q;                                 // [RQ2] [RQ12]
        else
        begin
          req_d.wr    = 1'b1;                            // [RQ3]
          req_d.addr  = addr_q;
          req_d.wdata = res_q;
        end
        busy_d  = 1'b0;
        done_d  = 1'b1;
        phase_d = SMAD_Q1;                               // [RQ14]
      end
      default:
        phase_d = SMAD_Q1;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    // every register is reset so the outputs are defined from the first edge
    if (rst)
    begin
      phase_q  <= SMAD_Q1;
      op_q     <= SMAD_OP_NONE;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      instr_q  <= 16'h0000;
      opnd_q   <= 8'h00;
      res_q    <= 8'h00;
      alu_q    <= 11'h000;
      acc_q    <= `SMAD_ACC_RESET;
      status_q <= `SMAD_STATUS_RESET;
      req_q    <= '0;
      addr_q   <= 12'h000;
    end
    else
    begin
      phase_q  <= phase_d;
      op_q     <= op_d;
      busy_q   <= busy_d;
      done_q   <= done_d;
      instr_q  <= instr_d;
      opnd_q   <= opnd_d;
      res_q    <= res_d;
      alu_q    <= alu_d;
      acc_q    <= acc_d;
      status_q <= status_d;
      req_q    <= req_d;
      addr_q   <= addr_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  // file_req.addr keeps the last resolved address between strobes
  assign file_req = req_q;
  assign acc      = acc_q;
  assign status   = status_q;
  assign busy     = busy_q;
  assign done     = done_q;

endmodule

// File: tb/smad_file_mem.sv
/*
  file memory partner for the subtract datapath.
  assumes rd and wr are one-cycle pulses and that read data is taken
  in the rd pulse cycle or the cycle after it.
*/
module smad_file_mem
(
  // clock
  input  wire logic                        ref_clk,
  // request and answer
  input  wire smad_pkg::smad_file_req_type file_req,
  output logic [7:0]                       file_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import smad_pkg::*;
  // ----
  // storage
  // ----
  logic [7:0] mem [4096];
  logic [7:0] hold_q = 8'h00;
  logic       rd_q = 1'b0;
  always @(posedge ref_clk)
  begin
    if (file_req.wr)
      mem[file_req.addr] <= file_req.wdata;
    rd_q <= file_req.rd;
    if (file_req.rd)
      hold_q <= mem[file_req.addr];
  end
  // past the hold cycle the data is inverted so a late sample cannot pass
  assign file_rdata = file_req.rd ? mem[file_req.addr] : rd_q ? hold_q : ~hold_q;
endmodule

// File: tb/smad_datapath_chk.sv
/*
  port checker for the subtract datapath.
  assumes it is bound to smad_datapath.
*/
module smad_datapath_chk
(
  // watched ports
  input wire logic                        ref_clk,
  input wire logic                        rst,
  input wire logic                        instr_valid,
  input wire logic [15:0]                 instr,
  input wire logic                        ext_set_en,
  input wire logic [3:0]                  bank_pointer,
  input wire logic [11:0]                 index_base,
  input wire smad_pkg::smad_file_req_type file_req,
  input wire logic [7:0]                  acc,
  input wire smad_pkg::smad_status_type   status,
  input wire logic                        busy,
  input wire logic                        done
);
  timeunit 1ns;
  timeprecision 1ns;
  import smad_pkg::*;
  // ----
  // properties
  // ----
  logic       fop;
  logic       take;
  logic [7:0] res;
  assign fop = instr[15:11] == 5'h0B;
  assign take = !busy && instr_valid && (fop || instr[15:8] == 8'h08);
  assign res = file_req.wr ? file_req.wdata : acc;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_take_busy: assert property (take |=> busy) else $error("busy not raised");
  a_done_delay: assert property (take |=> !done[*4] ##1 done) else $error("done late");
  a_read_file: assert property (take && fop |-> ##2 file_req.rd) else $error("no read");
  a_dest_file: assert property (take && fop && instr[9] |-> ##5 file_req.wr && $stable(acc))
    else $error("no file write");
  a_dest_acc: assert property (take && !(fop && instr[9]) |-> ##5 done && !file_req.wr) else $error("bad write");
  a_bank_addr: assert property (take && fop && instr[8] |-> ##2 file_req.rd && file_req.addr == {$past(bank_pointer),
    $past(instr[7:0], 2)}) else $error("bank address");
  a_index_addr: assert property (take && fop && !instr[8] && ext_set_en && instr[7:0] <= 8'h5F |-> ##2
    file_req.addr == $past(index_base) + {4'h0, $past(instr[7:0], 2)}) else $error("index address");
  a_flag_bits: assert property (done |-> status.neg == res[7] && status.zero == (res == 8'h00))
    else $error("flags");
  c_file_wr: cover property (take && fop && instr[9]);
  c_literal: cover property (take && !fop);
  c_borrow: cover property (done && !status.carry);
endmodule
bind smad_datapath smad_datapath_chk smad_datapath_chk_i (.ref_clk(ref_clk), .rst(rst),
  .instr_valid(instr_valid), .instr(instr), .ext_set_en(ext_set_en), .bank_pointer(bank_pointer),
  .index_base(index_base), .file_req(file_req), .acc(acc), .status(status), .busy(busy), .done(done));

// File: tb/subtract_instruction_datapath_tb.sv
/*
  self-checking bench for the subtract datapath.
  assumes the partner memory and the checker are compiled first.
*/
module subtract_instruction_datapath_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import smad_pkg::*;
  // ----
  // bench
  // ----
  logic ref_clk = 0, rst = 1, instr_valid = 0, ext_set_en = 0, busy, done, c_m = 0;
  logic [15:0] instr = 16'h0000;
  logic [3:0] bank_pointer = 4'h0;
  logic [11:0] index_base = 12'h000;
  logic [7:0] file_rdata, acc, acc_m = 8'h00;
  logic [4:0] st_m = 5'h00;
  smad_file_req_type file_req;
  smad_status_type status;
  int bad_count = 0, check_count = 0;
  always #25 ref_clk = ~ref_clk;
  smad_datapath smad_datapath_i (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .ext_set_en(ext_set_en), .bank_pointer(bank_pointer), .index_base(index_base), .file_rdata(file_rdata),
    .file_req(file_req), .acc(acc), .status(status), .busy(busy), .done(done));
  smad_file_mem smad_file_mem_i (.ref_clk(ref_clk), .file_req(file_req), .file_rdata(file_rdata));
  function automatic logic [12:0] calc(logic [7:0] a, b, logic bi);
    logic [8:0] t;
    logic [4:0] h;
    t = {1'b0, a} - {1'b0, b} - 9'(bi);
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(bi);
    return {t[7], (a[7] ^ b[7]) & (t[7] ^ a[7]), t[7:0] == 8'h00, ~h[4], ~t[8], t[7:0]};
  endfunction
  task automatic check(logic [12:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic op(logic [15:0] i, logic [11:0] fa, logic [7:0] fv);
    logic lit;
    logic [12:0] e;
    lit = i[15:8] == 8'h08;
    smad_file_mem_i.mem[fa] = fv;
    e = calc(lit ? i[7:0] : fv, acc_m, i[15:10] == 6'h16 && !c_m);
    acc_m = (lit || !i[9]) ? e[7:0] : acc_m;
    c_m = e[8];
    st_m = e[12:8];
    @(posedge ref_clk);
    instr <= i;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    repeat (8)
    begin
      @(posedge ref_clk);
      #1;
      if (done === 1'b1)
        break;
    end
    check(13'({done, busy}), 13'h0002);
    check({status, acc}, {e[12:8], acc_m});
    @(posedge ref_clk);
    #1;
    check(13'(smad_file_mem_i.mem[fa]), 13'((lit || !i[9]) ? fv : e[7:0]));
  endtask
  task automatic t_literal;
    op(16'h0803, 12'h000, 8'h00);
    op(16'h0802, 12'h000, 8'h00);
    $display("literal test finished");
  endtask
  task automatic t_borrow;
    op(16'h5880, 12'hF80, 8'h10);
    op(16'h5A80, 12'hF80, 8'h1B);
    $display("borrow test finished");
  endtask
  task automatic t_file;
    op(16'h5E20, 12'h020, 8'h05);
    @(posedge ref_clk);
    bank_pointer <= 4'h5;
    op(16'h5D10, 12'h510, acc_m);
    $display("file test finished");
  endtask
  task automatic t_index;
    @(posedge ref_clk);
    ext_set_en <= 1'b1;
    index_base <= 12'h300;
    op(16'h5C10, 12'h310, 8'h80);
    op(16'h5E70, 12'hF70, 8'h7F);
    $display("index test finished");
  endtask
  task automatic t_ignore;
    @(posedge ref_clk);
    instr <= 16'h0000;
    instr_valid <= 1'b1;
    repeat (6) @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    check(13'({done, busy}), 13'h0000);
    check({status, acc}, {st_m, acc_m});
    $display("ignore test finished");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_literal;
    t_borrow;
    t_file;
    t_index;
    t_ignore;
    report_and_stop;
  end
  // eight operations take under 5 us, so 20 us means a hang
  initial
  begin
    #20000;
    bad_count++;
    report_and_stop;
  end
endmodule
